// File: hw/frt_pkg.sv
// Constants shared by the free-running timer, capture channels and interval timers.
package frt_pkg;
  // Core clock and time base.
  localparam int CLK_PERIOD_NS = 5;
  localparam int STEP_NS = 250;
  localparam int STEP_CYCLES = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Free-running counter, tick and wrap periods.
  localparam int COUNT_W = 16;
  localparam int TICK_US = 1024;
  localparam int TICK_STEPS = TICK_US * 1000 / STEP_NS;
  localparam int TICK_BITS = $clog2(TICK_STEPS);
  localparam int WRAP_NS = 16384000;
  localparam int WRAP_STEPS = WRAP_NS / STEP_NS;
  // Capture slice, interval timer and wakeup timer.
  localparam int CAP_W = 8;
  localparam int SLICE_STEP = 4;
  localparam int PIT_W = 12;
  localparam int WAKE_BASE_US = 1024;
  localparam int WAKE_W = 24;
  // Interrupt mask bit positions.
  localparam int IRQ_TICK = 0;
  localparam int IRQ_WRAP = 1;
  localparam int IRQ_CAPA = 2;
  localparam int IRQ_CAPB = 3;
  localparam int IRQ_PIT = 4;
  localparam int IRQ_WAKE = 5;
  localparam int IRQ_N = 6;
  // Reset values.
  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [CAP_W-1:0] CAP_RST = 8'h00;
endpackage

// File: hw/frt_capture_chan.sv
// One capture channel: edge detector with separate rising and falling registers.
`timescale 1ns/10ps
`default_nettype none
module frt_capture_chan
  import frt_pkg::*;
#(
  parameter int W = CAP_W
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Pin and selection.
  input wire logic pin,
  input wire logic rise_en,
  input wire logic fall_en,
  input wire logic [W-1:0] load_data,
  // Captured values and load pulse.
  output logic [W-1:0] rise_q,
  output logic [W-1:0] fall_q,
  output logic loaded
);
  logic pin_prev_r;
  logic [W-1:0] rise_r, rise_nxt, fall_r, fall_nxt;
  logic loaded_r, loaded_nxt;
  logic rise_evt, fall_evt;

  ////////////////////////////////////////////////////////////////////////////
  // Edges are judged against the previous sample; the pin is already synchronous.
  assign rise_evt = rise_en & pin & ~pin_prev_r;
  assign fall_evt = fall_en & ~pin & pin_prev_r;

  // Each edge kind owns its register, so a fall never overwrites a rise time.
  always_comb
  begin
    rise_nxt = rise_evt ? load_data : rise_r; // R4 R5
    fall_nxt = fall_evt ? load_data : fall_r; // R4 R5
    loaded_nxt = rise_evt | fall_evt; // R7
  end

  // Registered state.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_prev_r <= 1'b0;
      rise_r <= CAP_RST;
      fall_r <= CAP_RST;
      loaded_r <= 1'b0;
    end
    else
    begin
      pin_prev_r <= pin;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
      loaded_r <= loaded_nxt;
    end
  end

  assign rise_q = rise_r;
  assign fall_q = fall_r;
  assign loaded = loaded_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_rise_load: assert property (@(posedge core_clk) disable iff (!reset_n) // R4
    rise_evt |=> rise_q == $past(load_data) && loaded)
    else $error("rising edge did not load the slice");
  chk_fall_keeps: assert property (@(posedge core_clk) disable iff (!reset_n) // R5
    fall_evt |=> rise_q == $past(rise_q) && fall_q == $past(load_data))
    else $error("falling edge disturbed the rising register");
  chk_load_cause: assert property (@(posedge core_clk) disable iff (!reset_n) // R7
    loaded |-> $past(rise_evt) || $past(fall_evt))
    else $error("load pulse without a selected edge");
endmodule
`default_nettype wire

// File: hw/frt_timer_top.sv
// Free-running counter with tick, wrap, two capture channels, interval and wakeup timers.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// (R1) Readable 16-bit free-running counter.
// (R2) Tick request every 1024 microseconds.
// (R3) Wrap request on counter overflow, 16.384 ms.
// (R4) Selected edge copies chosen counter byte.
// (R5) Separate rising and falling capture registers.
// (R6) Two 8-bit channels gang into 16 bits.
// (R7) Capture request on each capture load.
// (R8) 12-bit interval timer raises request.
// (R9) Wakeup timer requests periodically, even suspended.
// (R10) Every request individually maskable.
// (R11) Counter advances on fixed system-clock-derived steps.
module frt_timer_top
  import frt_pkg::*;
#(
  parameter int PIT_WIDTH = PIT_W,
  parameter int WAKE_WIDTH = WAKE_W,
  // Core cycles per counter step; at most 64 since the 8-bit wakeup prescaler counts four steps per microsecond.
  parameter int STEP_LEN = STEP_CYCLES
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Capture pins.
  input wire logic capture_pin_a,
  input wire logic capture_pin_b,
  // Capture control.
  input wire logic cap_rise_en,
  input wire logic cap_fall_en,
  input wire logic [1:0] cap_slice_sel,
  input wire logic cap_gang,
  // Interval and wakeup control.
  input wire logic pit_en,
  input wire logic [PIT_WIDTH-1:0] pit_period,
  input wire logic wake_en,
  input wire logic [1:0] wake_sel,
  input wire logic suspend,
  // Interrupt mask, one bit per source, high passes.
  input wire logic [IRQ_N-1:0] irq_mask,
  // Counter and captures.
  output logic [COUNT_W-1:0] free_count,
  output logic [CAP_W-1:0] cap_a_rise,
  output logic [CAP_W-1:0] cap_a_fall,
  output logic [CAP_W-1:0] cap_b_rise,
  output logic [CAP_W-1:0] cap_b_fall,
  // Interrupt request pulses.
  output logic tick_irq,
  output logic wrap_irq,
  output logic cap_a_irq,
  output logic cap_b_irq,
  output logic pit_irq,
  output logic wake_irq
);
  localparam logic [7:0] STEP_LAST = 8'(STEP_LEN - 1);
  localparam logic [7:0] US_LAST = 8'(STEP_LEN * (US_NS / STEP_NS) - 1);
  localparam logic [TICK_BITS-1:0] TICK_ZERO = '0;

  logic [7:0] pre_r, pre_nxt;
  logic step;
  logic [1:0] qus_r, qus_nxt;
  logic us_step;
  logic [COUNT_W-1:0] count_r, count_nxt;
  logic tick_evt, wrap_evt;
  logic [PIT_WIDTH-1:0] pit_r, pit_nxt;
  logic pit_evt;
  logic [7:0] wpre_r, wpre_nxt;
  logic [WAKE_WIDTH-1:0] wake_r, wake_nxt;
  logic [WAKE_WIDTH-1:0] wake_last;
  logic wake_evt;
  logic [CAP_W-1:0] slice, data_a, data_b;
  logic pin_b_sel;
  logic load_a, load_b;
  logic [IRQ_N-1:0] irq_r, irq_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Step prescaler. The counter steps every 250 ns so that 4096 steps give the
  // 1024 us tick and a full 16-bit wrap lands on 16.384 ms.
  always_comb
  begin
    step = (pre_r == STEP_LAST); // R11
    pre_nxt = step ? 8'h00 : pre_r + 8'h01;
    us_step = step && (qus_r == 2'h3);
    qus_nxt = step ? qus_r + 2'h1 : qus_r;
  end

  // Free-running counter. Suspend freezes it; firmware reads it at any time.
  always_comb
  begin
    count_nxt = count_r;
    if (step && !suspend)
    begin
      count_nxt = count_r + 16'h0001; // R1 R11
    end
    tick_evt = step && !suspend && (count_nxt[TICK_BITS-1:0] == TICK_ZERO); // R2
    wrap_evt = step && !suspend && (count_r == 16'hFFFF); // R3
  end

  // Interval timer: counts microseconds down and reloads, period is setting plus one.
  always_comb
  begin
    pit_nxt = pit_r;
    pit_evt = 1'b0;
    if (!pit_en)
    begin
      pit_nxt = pit_period;
    end
    else if (us_step && !suspend)
    begin
      if (pit_r == '0)
      begin
        pit_evt = 1'b1; // R8
        pit_nxt = pit_period;
      end
      else
      begin
        pit_nxt = pit_r - 1'b1;
      end
    end
  end

  // Wakeup timer keeps its own microsecond prescaler so it still runs while suspended.
  always_comb
  begin
    wake_last = WAKE_WIDTH'(WAKE_BASE_US << wake_sel) - 1'b1;
    wpre_nxt = (wpre_r == US_LAST) ? 8'h00 : wpre_r + 8'h01;
    wake_nxt = wake_r;
    wake_evt = 1'b0;
    if (!wake_en)
    begin
      wake_nxt = '0;
    end
    else if (wpre_r == US_LAST)
    begin
      wake_evt = (wake_r >= wake_last); // R9
      wake_nxt = wake_evt ? '0 : wake_r + 1'b1;
    end
  end

  // Time base registers.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_r <= 8'h00;
      qus_r <= 2'h0;
      count_r <= COUNT_RST;
      pit_r <= '0;
      wpre_r <= 8'h00;
      wake_r <= '0;
    end
    else
    begin
      pre_r <= pre_nxt;
      qus_r <= qus_nxt;
      count_r <= count_nxt;
      pit_r <= pit_nxt;
      wpre_r <= wpre_nxt;
      wake_r <= wake_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slice select: byte window at 4-bit steps, codes 2 and 3 both take the top byte.
  // Ganged mode routes pin A to both channels, low byte to A and high byte to B.
  always_comb
  begin
    case (cap_slice_sel)
      2'h0: slice = count_r[7:0];
      2'h1: slice = count_r[11:4];
      default: slice = count_r[15:8];
    endcase
    data_a = cap_gang ? count_r[7:0] : slice; // R4 R6
    data_b = cap_gang ? count_r[15:8] : slice; // R6
    pin_b_sel = cap_gang ? capture_pin_a : capture_pin_b; // R6
  end

  frt_capture_chan #(.W(CAP_W)) u_chan_a (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pin(capture_pin_a),
    .rise_en(cap_rise_en),
    .fall_en(cap_fall_en),
    .load_data(data_a),
    .rise_q(cap_a_rise),
    .fall_q(cap_a_fall),
    .loaded(load_a)
  );

  frt_capture_chan #(.W(CAP_W)) u_chan_b (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pin(pin_b_sel),
    .rise_en(cap_rise_en),
    .fall_en(cap_fall_en),
    .load_data(data_b),
    .rise_q(cap_b_rise),
    .fall_q(cap_b_fall),
    .loaded(load_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request pulses, each gated by its own mask bit. Capture requests follow the
  // register load by one cycle so the value is already readable when they fire.
  always_comb
  begin
    irq_nxt[IRQ_TICK] = tick_evt & irq_mask[IRQ_TICK]; // R2 R10
    irq_nxt[IRQ_WRAP] = wrap_evt & irq_mask[IRQ_WRAP]; // R3 R10
    irq_nxt[IRQ_CAPA] = load_a & irq_mask[IRQ_CAPA]; // R7 R10
    irq_nxt[IRQ_CAPB] = load_b & irq_mask[IRQ_CAPB]; // R7 R10
    irq_nxt[IRQ_PIT] = pit_evt & irq_mask[IRQ_PIT]; // R8 R10
    irq_nxt[IRQ_WAKE] = wake_evt & irq_mask[IRQ_WAKE]; // R9 R10
  end

  // Request registers.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_r <= '0;
    end
    else
    begin
      irq_r <= irq_nxt;
    end
  end

  assign free_count = count_r;
  assign tick_irq = irq_r[IRQ_TICK];
  assign wrap_irq = irq_r[IRQ_WRAP];
  assign cap_a_irq = irq_r[IRQ_CAPA];
  assign cap_b_irq = irq_r[IRQ_CAPB];
  assign pit_irq = irq_r[IRQ_PIT];
  assign wake_irq = irq_r[IRQ_WAKE];

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_count_step: assert property (@(posedge core_clk) disable iff (!reset_n) // R1
    step && !suspend |=> free_count == $past(free_count) + 16'h0001)
    else $error("counter did not advance on a step");
  chk_step_spacing: assert property (@(posedge core_clk) disable iff (!reset_n) // R11
    step && STEP_LEN == STEP_CYCLES |=> !step [*8] ##42 step)
    else $error("step spacing is not 50 cycles");
  chk_step_period: assert property (@(posedge core_clk) disable iff (!reset_n) // R11
    step |-> ##STEP_LEN step)
    else $error("next step is not one step length later");
  chk_tick_cause: assert property (@(posedge core_clk) disable iff (!reset_n) // R2
    tick_irq |-> free_count[11:0] == 12'h000 && $past(irq_mask[IRQ_TICK]))
    else $error("tick request off the 4096-step boundary");
  chk_wrap_cause: assert property (@(posedge core_clk) disable iff (!reset_n) // R3
    wrap_irq |-> free_count == 16'h0000 && tick_irq == $past(irq_mask[IRQ_TICK]))
    else $error("wrap request without overflow");
  chk_gang_high: assert property (@(posedge core_clk) disable iff (!reset_n) // R6
    cap_gang && cap_rise_en && $rose(capture_pin_a) |=> cap_b_rise == $past(free_count[15:8])
      && cap_a_rise == $past(free_count[7:0]))
    else $error("ganged capture split wrong");
  chk_cap_irq: assert property (@(posedge core_clk) disable iff (!reset_n) // R7
    load_a && irq_mask[IRQ_CAPA] |=> cap_a_irq)
    else $error("capture load raised no request");
  chk_pit_reload: assert property (@(posedge core_clk) disable iff (!reset_n) // R8
    pit_irq |-> pit_r == $past(pit_period) && $past(pit_en))
    else $error("interval request without reload");
  chk_wake_susp: assert property (@(posedge core_clk) disable iff (!reset_n) // R9
    wake_irq |-> $past(wake_en) && $past(wpre_r) == US_LAST)
    else $error("wakeup request out of step");
  chk_mask_gate: assert property (@(posedge core_clk) disable iff (!reset_n) // R10
    (pit_irq |-> $past(irq_mask[IRQ_PIT])) and (cap_b_irq |-> $past(irq_mask[IRQ_CAPB])))
    else $error("masked request reached the output");
  cov_tick: cover property (@(posedge core_clk) disable iff (!reset_n) tick_irq);
  cov_wrap: cover property (@(posedge core_clk) disable iff (!reset_n) wrap_irq);
  cov_gang: cover property (@(posedge core_clk) disable iff (!reset_n) cap_gang && cap_b_irq);
  cov_wake_susp: cover property (@(posedge core_clk) disable iff (!reset_n) suspend && wake_irq);
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the free-running timer, capture channels and interval timer.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import frt_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic pin_a = 1'b0;
  logic pin_b = 1'b0;
  logic rise_en = 1'b0;
  logic fall_en = 1'b0;
  logic [1:0] slice_sel = 2'h0;
  logic gang = 1'b0;
  logic pit_en = 1'b0;
  logic [PIT_W-1:0] pit_period = 12'h002;
  logic wake_en = 1'b1;
  logic [1:0] wake_sel = 2'h0;
  logic suspend = 1'b0;
  logic [IRQ_N-1:0] irq_mask = 6'h3F;
  logic [COUNT_W-1:0] free_count;
  logic [CAP_W-1:0] a_r, a_f, b_r, b_f;
  logic tick_irq, wrap_irq, cap_a_irq, cap_b_irq, pit_irq, wake_irq;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  // Second copy with a one-cycle step, so tick, wrap and wakeup periods fit in the run.
  localparam int WAKE_STEPS = WAKE_BASE_US * US_NS / STEP_NS;
  localparam int MASK_AT = 3 * TICK_STEPS;
  localparam int FAST_END = WRAP_STEPS + 2 * WAKE_STEPS;
  logic f_suspend = 1'b0;
  logic [1:0] f_wake_sel = 2'h0;
  logic [IRQ_N-1:0] f_mask = 6'h3F;
  logic [COUNT_W-1:0] f_count;
  logic f_tick, f_wrap, f_wake;

  frt_timer_top frt_timer_top_i (.core_clk(core_clk), .reset_n(reset_n),
    .capture_pin_a(pin_a), .capture_pin_b(pin_b), .cap_rise_en(rise_en),
    .cap_fall_en(fall_en), .cap_slice_sel(slice_sel), .cap_gang(gang), .pit_en(pit_en),
    .pit_period(pit_period), .wake_en(wake_en), .wake_sel(wake_sel), .suspend(suspend),
    .irq_mask(irq_mask), .free_count(free_count), .cap_a_rise(a_r), .cap_a_fall(a_f),
    .cap_b_rise(b_r), .cap_b_fall(b_f), .tick_irq(tick_irq), .wrap_irq(wrap_irq),
    .cap_a_irq(cap_a_irq), .cap_b_irq(cap_b_irq), .pit_irq(pit_irq), .wake_irq(wake_irq));

  frt_timer_top #(.STEP_LEN(1)) frt_timer_top_fast_i (.core_clk(core_clk), .reset_n(reset_n),
    .capture_pin_a(pin_a), .capture_pin_b(pin_b), .cap_rise_en(rise_en),
    .cap_fall_en(fall_en), .cap_slice_sel(slice_sel), .cap_gang(gang), .pit_en(pit_en),
    .pit_period(pit_period), .wake_en(wake_en), .wake_sel(f_wake_sel), .suspend(f_suspend),
    .irq_mask(f_mask), .free_count(f_count), .cap_a_rise(), .cap_a_fall(),
    .cap_b_rise(), .cap_b_fall(), .tick_irq(f_tick), .wrap_irq(f_wrap),
    .cap_a_irq(), .cap_b_irq(), .pit_irq(), .wake_irq(f_wake));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, and a count of edges since reset release that models the counter.
  always #2.5 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    cyc <= reset_n ? cyc + 1 : 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers; inputs always change 1 ns after the rising edge.
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  function automatic logic [7:0] slice_of(input int c, input logic [1:0] sel);
    logic [15:0] v;
    v = c[15:0];
    return (sel == 2'h0) ? v[7:0] : (sel == 2'h1) ? v[11:4] : v[15:8];
  endfunction

  // One pin edge; a register never loaded must still show its reset value.
  task automatic cap_edge(input logic on_b, input logic lvl, input logic [1:0] sel,
                          input logic load, input logic irq);
    logic [7:0] exp;
    logic [7:0] got;
    slice_sel = sel;
    wait_n(1);
    exp = load ? slice_of(cyc / 50, sel) : 8'h00;
    if (on_b)
    begin
      pin_b = lvl;
    end
    else
    begin
      pin_a = lvl;
    end
    wait_n(1);
    got = on_b ? (lvl ? b_r : b_f) : (lvl ? a_r : a_f);
    cmp_val({8'h00, got}, {8'h00, exp});
    wait_n(1);
    cmp_val({15'h0000, on_b ? cap_b_irq : cap_a_irq}, {15'h0000, irq});
    wait_n(1);
    cmp_val({15'h0000, on_b ? cap_b_irq : cap_a_irq}, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic s_reset_count();
    cmp_val(free_count, 16'h0000);
    wait_n(49);
    cmp_val(free_count, 16'h0000);
    wait_n(1);
    cmp_val(free_count, 16'h0001);
    wait_n(13000);
    cmp_val(free_count, 16'(cyc / 50));
  endtask

  // Rising edges load at every slice, falling edges are ignored when disabled.
  task automatic s_rise_a();
    rise_en = 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      cap_edge(1'b0, 1'b1, 2'(s), 1'b1, 1'b1);
      cap_edge(1'b0, 1'b0, 2'(s), 1'b0, 1'b0);
    end
  endtask

  task automatic s_both_b();
    fall_en = 1'b1;
    cap_edge(1'b1, 1'b1, 2'h1, 1'b1, 1'b1);
    cap_edge(1'b1, 1'b0, 2'h2, 1'b1, 1'b1);
  endtask

  // Masked source still loads its register but the request is dropped.
  task automatic s_mask_cap();
    irq_mask[IRQ_CAPB] = 1'b0;
    cap_edge(1'b1, 1'b1, 2'h0, 1'b1, 1'b0);
    irq_mask[IRQ_CAPB] = 1'b1;
  endtask

  task automatic s_gang();
    int c;
    gang = 1'b1;
    wait_n(1);
    c = cyc / 50;
    pin_a = 1'b1;
    wait_n(1);
    cmp_val({8'h00, a_r}, {8'h00, slice_of(c, 2'h0)});
    cmp_val({8'h00, b_r}, {8'h00, slice_of(c, 2'h2)});
    c = cyc / 50;
    pin_a = 1'b0;
    wait_n(1);
    cmp_val({8'h00, a_f}, {8'h00, slice_of(c, 2'h0)});
    cmp_val({8'h00, b_f}, {8'h00, slice_of(c, 2'h2)});
    wait_n(2);
    gang = 1'b0;
  endtask

  // Interval of period+1 microseconds, 200 cycles each, then masked.
  task automatic s_pit();
    int gap;
    int k;
    pit_en = 1'b1;
    k = 0;
    while (pit_irq !== 1'b1 && k < 1000)
    begin
      wait_n(1);
      k++;
    end
    cmp_val(16'(k < 1000), 16'h0001);
    gap = 0;
    wait_n(1);
    while (pit_irq !== 1'b1 && gap < 1000)
    begin
      wait_n(1);
      gap++;
    end
    cmp_val(16'(gap + 1), 16'h0258);
    irq_mask[IRQ_PIT] = 1'b0;
    k = 0;
    repeat (1300)
    begin
      wait_n(1);
      if (pit_irq !== 1'b0) k++;
    end
    cmp_val(16'(k), 16'h0000);
    irq_mask[IRQ_PIT] = 1'b1;
  endtask

  // Suspend freezes the counter; chosen mid-step so no step is pending.
  task automatic s_suspend();
    logic [15:0] exp;
    while (cyc % 50 != 10) wait_n(1);
    exp = 16'(cyc / 50);
    suspend = 1'b1;
    wait_n(300);
    cmp_val(free_count, exp);
    suspend = 1'b0;
  endtask

  // Fast copy: tick and wakeup every 4096 steps, wrap at 65536, one tick and one wakeup masked.
  // After the wrap, suspend freezes the counter while the doubled wakeup period runs on.
  task automatic s_fast();
    logic e_tick;
    logic e_wake;
    while (cyc < FAST_END)
    begin
      wait_n(1);
      e_tick = (cyc <= WRAP_STEPS) && (cyc % TICK_STEPS == 0) && (cyc != MASK_AT);
      e_wake = (cyc <= WRAP_STEPS) ? (cyc % WAKE_STEPS == 0) && (cyc != MASK_AT)
                                   : (cyc == FAST_END);
      cmp_val({15'h0000, f_tick}, {15'h0000, e_tick});
      cmp_val({15'h0000, f_wrap}, {15'h0000, cyc == WRAP_STEPS});
      cmp_val({15'h0000, f_wake}, {15'h0000, e_wake});
      if (cyc == WRAP_STEPS - 1)
      begin
        cmp_val(f_count, 16'hFFFF);
      end
      if (cyc == MASK_AT - 8)
      begin
        f_mask = 6'h1E;
      end
      if (cyc == MASK_AT + 8)
      begin
        f_mask = 6'h3F;
      end
      if (cyc == WRAP_STEPS)
      begin
        f_suspend = 1'b1;
        f_wake_sel = 2'h1;
      end
    end
    cmp_val(f_count, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and watchdog.
  task automatic complete_run();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    // The fast copy needs about 74000 cycles; the slow scenarios run alongside it.
    #(5 * 80000);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    wait_n(8);
    reset_n = 1'b1;
    fork
      s_fast();
      begin
        s_reset_count();
        s_rise_a();
        s_both_b();
        s_mask_cap();
        s_gang();
        s_pit();
        s_suspend();
      end
    join
    complete_run();
  end
endmodule
`default_nettype wire
